// file: src/ssip_dev.sv
`timescale 1ns/10ps
`default_nettype none
module ssip_dev #(
  parameter int unsigned POS_W = ssip_pkg::POS_W,
  parameter int unsigned RDY_CYC = ssip_pkg::RDY_CYC
) (
  input wire logic clk_sys, // System clock.
  input wire logic rstn, // Synchronous reset, active low.
  ssip_if.dev lnk, // Serial link.
  input wire logic shaft_step, // One-cycle pulse per position step.
  input wire logic shaft_cw, // Step is clockwise when high.
  input wire logic dir_rev, // Reverse counting sense when high.
  output logic [POS_W-1:0] pos_now, // Live position count.
  output logic busy // High while a word is in flight.
);
  // Widths and end values of the bit counter and the hold timer.
  localparam int unsigned CW = $clog2(POS_W + 2);
  localparam int unsigned TW = $clog2(RDY_CYC + 1);
  localparam logic [CW-1:0] LAST_RISE = CW'(POS_W);
  localparam logic [TW-1:0] TMR_END = TW'(RDY_CYC - 1);

  // One-hot sequencer states.
  typedef enum logic [2:0] {
    D_IDLE = 3'b001,
    D_SHIFT = 3'b010,
    D_HOLD = 3'b100
  } ssip_dst_e;

  // Sequencer state.
  ssip_dst_e st_r;
  ssip_dst_e st_nxt;
  // Link clock filter and its edges.
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic lvl_r;
  logic lvl_nxt;
  logic fall_w;
  logic rise_w;
  // Direction pin filter.
  logic [2:0] dsync_r;
  logic [2:0] dsync_nxt;
  logic dir_r;
  logic dir_nxt;
  // Live position and the shifter that holds the captured word.
  logic [POS_W-1:0] pos_r;
  logic [POS_W-1:0] pos_nxt;
  logic [POS_W-1:0] shreg_r;
  logic [POS_W-1:0] shreg_nxt;
  // Bit counter and hold timer.
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [TW-1:0] tmr_r;
  logic [TW-1:0] tmr_nxt;
  // Registered outputs.
  logic sdata_r;
  logic sdata_nxt;
  logic busy_r;
  logic busy_nxt;

  // The link clock passes three flops; a new level counts once the last two agree.
  always_comb begin
    sync_nxt = {sync_r[1:0], lnk.sclk};
    lvl_nxt = lvl_r;
    if (sync_r[1] == sync_r[2]) begin
      lvl_nxt = sync_r[2];
    end
  end

  // Edges are seen when the filtered level changes.
  assign fall_w = lvl_r & ~lvl_nxt;
  assign rise_w = ~lvl_r & lvl_nxt;

  // Synchroniser and filtered level registers.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      sync_r <= ssip_pkg::SYNC_RST;
      lvl_r <= ssip_pkg::IDLE_LVL;
    end else begin
      sync_r <= sync_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  // The direction pin is asynchronous too; filter it before it steers the counter.
  always_comb begin
    dsync_nxt = {dsync_r[1:0], dir_rev};
    dir_nxt = dir_r;
    if (dsync_r[1] == dsync_r[2]) begin
      dir_nxt = dsync_r[2];
    end
  end

  // Direction filter registers.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dsync_r <= '0;
      dir_r <= 1'b0;
    end else begin
      dsync_r <= dsync_nxt;
      dir_r <= dir_nxt;
    end
  end

  // Live position counter; direction input flips the counting sense.
  always_comb begin
    pos_nxt = pos_r;
    if (shaft_step) begin
      if (shaft_cw ^ dir_r) begin
        pos_nxt = pos_r + 1'b1;
      end else begin
        pos_nxt = pos_r - 1'b1;
      end
    end
  end

  // Position register wraps modulo the resolution.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pos_r <= '0;
    end else begin
      pos_r <= pos_nxt;
    end
  end

  // Transfer sequencer: capture, shift out, then hold data low.
  always_comb begin
    st_nxt = st_r;
    shreg_nxt = shreg_r;
    cnt_nxt = cnt_r;
    tmr_nxt = tmr_r;
    sdata_nxt = sdata_r;
    case (st_r)
      D_IDLE: begin
        sdata_nxt = ssip_pkg::IDLE_LVL;
        tmr_nxt = '0;
        if (fall_w) begin
          shreg_nxt = pos_r;
          cnt_nxt = '0;
          st_nxt = D_SHIFT;
        end
      end
      D_SHIFT: begin
        if (rise_w) begin
          tmr_nxt = '0;
          // The rise after the last bit ends the word and starts the low hold.
          if (cnt_r == LAST_RISE) begin
            sdata_nxt = 1'b0;
            st_nxt = D_HOLD;
          end else begin
            sdata_nxt = shreg_r[POS_W-1];
            shreg_nxt = {shreg_r[POS_W-2:0], 1'b0};
            cnt_nxt = cnt_r + 1'b1;
          end
        end else if (fall_w) begin
          tmr_nxt = '0;
        end else if (lvl_r && cnt_r != '0) begin
          // A master that stops mid-word leaves the clock high; give up after the hold time.
          if (tmr_r == TMR_END) begin
            sdata_nxt = 1'b0;
            tmr_nxt = '0;
            st_nxt = D_HOLD;
          end else begin
            tmr_nxt = tmr_r + 1'b1;
          end
        end
      end
      D_HOLD: begin
        // Clock edges are ignored here; the master must wait for the line to rise.
        sdata_nxt = 1'b0;
        if (tmr_r == TMR_END) begin
          sdata_nxt = ssip_pkg::IDLE_LVL;
          tmr_nxt = '0;
          st_nxt = D_IDLE;
        end else begin
          tmr_nxt = tmr_r + 1'b1;
        end
      end
      default: begin
        sdata_nxt = ssip_pkg::IDLE_LVL;
        st_nxt = D_IDLE;
      end
    endcase
    busy_nxt = (st_nxt != D_IDLE);
  end

  // Sequencer registers.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_r <= D_IDLE;
      shreg_r <= '0;
      cnt_r <= '0;
      tmr_r <= '0;
      sdata_r <= ssip_pkg::IDLE_LVL;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      shreg_r <= shreg_nxt;
      cnt_r <= cnt_nxt;
      tmr_r <= tmr_nxt;
      sdata_r <= sdata_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Outputs come straight from flops.
  assign lnk.sdata = sdata_r;
  assign pos_now = pos_r;
  assign busy = busy_r;
endmodule : ssip_dev
`default_nettype wire

// file: src/ssip_if.sv
`timescale 1ns/10ps
`default_nettype none
// Serial link: clock from the master, data from the device.
interface ssip_if;
  logic sclk;
  logic sdata;
  modport dev (input sclk, output sdata);
  modport mst (output sclk, input sdata);
endinterface : ssip_if
`default_nettype wire

// file: src/ssip_mst.sv
`timescale 1ns/10ps
`default_nettype none
module ssip_mst #(
  parameter int unsigned POS_W = ssip_pkg::POS_W,
  parameter int unsigned HALF_CYC = ssip_pkg::HALF_CYC,
  parameter int unsigned GAP_CYC = ssip_pkg::GAP_CYC,
  parameter int unsigned STALE_CYC = ssip_pkg::STALE_CYC
) (
  input wire logic clk_sys, // System clock.
  input wire logic rstn, // Synchronous reset, active low.
  ssip_if.mst lnk, // Serial link.
  input wire logic rd_req, // One-cycle pulse asking for a word.
  output logic rd_busy, // High while a request is pending or running.
  output logic [POS_W-1:0] rd_word, // Last word received.
  output logic rd_valid, // One-cycle pulse with a new word.
  output logic rd_stale // Word follows a long pause; discard it.
);
  localparam int unsigned CW = $clog2(POS_W + 2);
  localparam int unsigned HW = $clog2(HALF_CYC + 1);
  localparam int unsigned GW = $clog2(GAP_CYC + 1);
  localparam int unsigned SW = $clog2(STALE_CYC + 1);
  localparam logic [CW-1:0] LAST_RISE = CW'(POS_W + 1);
  localparam logic [HW-1:0] HALF_END = HW'(HALF_CYC - 1);
  localparam logic [GW-1:0] GAP_END = GW'(GAP_CYC);
  localparam logic [SW-1:0] STALE_END = SW'(STALE_CYC);

  typedef enum logic [3:0] {
    M_IDLE = 4'b0001,
    M_LOW = 4'b0010,
    M_HIGH = 4'b0100,
    M_WAIT = 4'b1000
  } ssip_mst_e;

  ssip_mst_e st_r;
  ssip_mst_e st_nxt;
  logic [2:0] sync_r;
  logic [2:0] sync_nxt;
  logic busy_nxt;
  logic sd_r;
  logic sd_nxt;
  logic pend_r;
  logic pend_nxt;
  logic [HW-1:0] hc_r;
  logic [HW-1:0] hc_nxt;
  logic [CW-1:0] rise_r;
  logic [CW-1:0] rise_nxt;
  logic [GW-1:0] gap_r;
  logic [GW-1:0] gap_nxt;
  logic [SW-1:0] idle_r;
  logic [SW-1:0] idle_nxt;
  logic [POS_W-1:0] sh_r;
  logic [POS_W-1:0] sh_nxt;
  logic [POS_W-1:0] word_r;
  logic [POS_W-1:0] word_nxt;
  logic sclk_r;
  logic sclk_nxt;
  logic valid_r;
  logic valid_nxt;
  logic stale_r;
  logic stale_nxt;
  logic tick_w;
  logic start_w;

  // Half-period tick of the clock divider.
  assign tick_w = (hc_r == HALF_END);
  // A start needs a request, the rate gap elapsed and the data line back high.
  assign start_w = (st_r == M_IDLE) && pend_r && (gap_r == GAP_END) && sd_r;

  // Link clock generation, bit capture and bookkeeping.
  always_comb begin
    st_nxt = st_r;
    sync_nxt = {sync_r[1:0], lnk.sdata};
    sd_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : sd_r;
    pend_nxt = rd_req | (pend_r & ~start_w);
    hc_nxt = tick_w ? '0 : hc_r + 1'b1;
    rise_nxt = rise_r;
    gap_nxt = (gap_r == GAP_END) ? gap_r : gap_r + 1'b1;
    idle_nxt = (idle_r == STALE_END) ? idle_r : idle_r + 1'b1;
    sh_nxt = sh_r;
    word_nxt = word_r;
    sclk_nxt = sclk_r;
    valid_nxt = 1'b0;
    stale_nxt = stale_r;
    case (st_r)
      M_IDLE: begin
        sclk_nxt = ssip_pkg::IDLE_LVL;
        hc_nxt = '0;
        if (start_w) begin
          sclk_nxt = 1'b0;
          rise_nxt = '0;
          gap_nxt = '0;
          st_nxt = M_LOW;
        end
      end
      M_LOW: begin
        if (tick_w) begin
          sclk_nxt = 1'b1;
          rise_nxt = rise_r + 1'b1;
          st_nxt = M_HIGH;
        end
      end
      // The bit is sampled at the end of the high half; the round trip needs a half of nine cycles or more.
      M_HIGH: begin
        if (tick_w) begin
          if (rise_r == LAST_RISE) begin
            st_nxt = M_WAIT;
          end else begin
            sh_nxt = {sh_r[POS_W-2:0], sd_r};
            sclk_nxt = 1'b0;
            st_nxt = M_LOW;
          end
        end
      end
      M_WAIT: begin
        hc_nxt = '0;
        if (sd_r) begin
          word_nxt = sh_r;
          valid_nxt = 1'b1;
          stale_nxt = (idle_r == STALE_END);
          idle_nxt = '0;
          st_nxt = M_IDLE;
        end
      end
      default: begin
        sclk_nxt = ssip_pkg::IDLE_LVL;
        st_nxt = M_IDLE;
      end
    endcase
    busy_nxt = pend_nxt | (st_nxt != M_IDLE);
  end

  // All master registers; the data pin passes three flops first.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_r <= M_IDLE;
      sync_r <= ssip_pkg::SYNC_RST;
      sd_r <= ssip_pkg::IDLE_LVL;
      pend_r <= 1'b0;
      hc_r <= '0;
      rise_r <= '0;
      gap_r <= GAP_END;
      idle_r <= STALE_END;
      sh_r <= '0;
      word_r <= '0;
      sclk_r <= ssip_pkg::IDLE_LVL;
      valid_r <= 1'b0;
      stale_r <= 1'b0;
      rd_busy <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sync_r <= sync_nxt;
      sd_r <= sd_nxt;
      pend_r <= pend_nxt;
      hc_r <= hc_nxt;
      rise_r <= rise_nxt;
      gap_r <= gap_nxt;
      idle_r <= idle_nxt;
      sh_r <= sh_nxt;
      word_r <= word_nxt;
      sclk_r <= sclk_nxt;
      valid_r <= valid_nxt;
      stale_r <= stale_nxt;
      rd_busy <= busy_nxt;
    end
  end

  assign lnk.sclk = sclk_r;
  assign rd_word = word_r;
  assign rd_valid = valid_r;
  assign rd_stale = stale_r;
endmodule : ssip_mst
`default_nettype wire

// file: src/ssip_pkg.sv
// Behaviour
// - Idle link: clock high, data high.
// - First falling clock edge starts a word.
// - Bits leave on rising edges, MSB first.
// - An n-bit word takes n+1 rising edges.
// - Data low after last edge until ready.
// - Master holds clock high until data returns.
// - Position word refreshed per read-out, not continuously.
// - Master flags first word after long pause as stale.
// - Master clock between minimum and maximum rate.
// - Master limits read-outs per second.
// - Word length equals resolution, at most 13.
// - Default count rises with clockwise rotation.
package ssip_pkg;
  // System clock rate in hertz.
  localparam int unsigned CLK_HZ = 100_000_000;
  // Resolution and word length in bits.
  localparam int unsigned POS_W = 13;
  // Link clock limits in hertz.
  localparam int unsigned SCLK_MIN_HZ = 100_000;
  localparam int unsigned SCLK_MAX_HZ = 500_000;
  // Highest read-out rate per second.
  localparam int unsigned RATE_MAX_PER_S = 15_000;
  // Half period of the master clock at the highest rate, rounded up.
  localparam int unsigned HALF_CYC = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
  // Least spacing between two read-out starts, rounded up.
  localparam int unsigned GAP_CYC = (CLK_HZ + RATE_MAX_PER_S - 1) / RATE_MAX_PER_S;
  // Time the device keeps data low after a word, in microseconds.
  localparam int unsigned RDY_US = 20;
  localparam int unsigned RDY_CYC = RDY_US * (CLK_HZ / 1_000_000);
  // Idle time after which the next word counts as stale, in microseconds.
  localparam int unsigned STALE_US = 1000;
  localparam int unsigned STALE_CYC = STALE_US * (CLK_HZ / 1_000_000);
  // Level of both lines while idle.
  localparam logic IDLE_LVL = 1'b1;
  // Reset value of the link pin synchronisers.
  localparam logic [2:0] SYNC_RST = 3'h7;
endpackage : ssip_pkg

// file: verif/ssip_checker.sv
`timescale 1ns/10ps
`default_nettype none
module ssip_checker #(
  parameter int unsigned POS_W = ssip_pkg::POS_W,
  parameter int unsigned HALF_CYC = ssip_pkg::HALF_CYC,
  parameter int unsigned GAP_CYC = ssip_pkg::GAP_CYC
) (
  input wire logic clk_sys, // System clock.
  input wire logic rstn, // Reset, active low.
  input wire logic sclk, // Link clock.
  input wire logic sdata // Link data.
);
  logic act_r, act_nxt, sclk_r, sdata_r;
  logic [4:0] rise_r, rise_nxt;
  logic [15:0] gap_r, gap_nxt;
  logic [15:0] half_r, half_nxt;
  // Tracks a frame from its idle start edge to the data line's return high.
  always_comb begin
    act_nxt = act_r;
    rise_nxt = rise_r;
    gap_nxt = (gap_r < 16'(GAP_CYC)) ? gap_r + 16'h1 : gap_r;
    half_nxt = (sclk != sclk_r) ? 16'h1 : ((half_r == 16'hFFFF) ? half_r : half_r + 16'h1);
    if (!act_r && sclk_r && !sclk) begin
      act_nxt = 1'b1;
      rise_nxt = 5'h0;
      gap_nxt = 16'h1;
    end
    if (act_r && !sclk_r && sclk) rise_nxt = rise_r + 5'h1;
    if (act_r && rise_r == 5'(POS_W + 1) && !sdata_r && sdata) act_nxt = 1'b0;
  end
  // Registers the tracker; the gap count starts out as already elapsed.
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      act_r <= 1'b0;
      rise_r <= 5'h0;
      gap_r <= 16'(GAP_CYC);
      half_r <= 16'h0;
      sclk_r <= 1'b1;
      sdata_r <= 1'b1;
    end else begin
      act_r <= act_nxt;
      rise_r <= rise_nxt;
      gap_r <= gap_nxt;
      half_r <= half_nxt;
      sclk_r <= sclk;
      sdata_r <= sdata;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  idle_data_a: assert property (!act_r |-> sdata) else $error("data low while idle.");
  idle_clock_a: assert property (!act_r && !sclk |-> sclk_r) else $error("clock low while idle.");
  rise_count_a: assert property (act_r |-> rise_r <= 5'(POS_W + 1)) else $error("too many rises.");
  end_low_a: assert property (act_r && rise_r == 5'(POS_W) && $rose(sclk) |-> ##[1:8] !sdata)
    else $error("data not low after last rise.");
  hold_high_a: assert property (act_r && rise_r == 5'(POS_W + 1) |-> sclk) else $error("clock low in hold.");
  low_stable_a: assert property (!sclk && !sclk_r |-> $stable(sdata)) else $error("data moved in low half.");
  low_half_a: assert property (!sclk_r && sclk |-> half_r == 16'(HALF_CYC)) else $error("low half length wrong.");
  high_half_a: assert property (act_r && sclk_r && !sclk |-> half_r == 16'(HALF_CYC))
    else $error("high half length wrong.");
  start_gap_a: assert property (!act_r && $fell(sclk) |-> gap_r == 16'(GAP_CYC))
    else $error("frames started too close.");
  cover property (!act_r && $fell(sclk));
  cover property (act_r && rise_r == 5'(POS_W + 1) && !sdata);
  cover property (act_r && rise_r == 5'(POS_W + 1) && $rose(sdata));
endmodule : ssip_checker
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam int unsigned PW = ssip_pkg::POS_W;
  // Half period of the master's link clock; the sampling round trip needs nine cycles or more.
  localparam int unsigned HC = 12;
  logic clk_sys, rstn, shaft_step, shaft_cw, dir_rev, rd_req, busy, rd_busy, rd_valid, rd_stale;
  logic [PW-1:0] pos_now, rd_word, exp_pos, wire_w;
  int failures, comparisons, nfall;
  ssip_if u_ssip_if ();
  ssip_dev #(.RDY_CYC(20)) u_ssip_dev (.clk_sys(clk_sys), .rstn(rstn), .lnk(u_ssip_if.dev),
    .shaft_step(shaft_step), .shaft_cw(shaft_cw), .dir_rev(dir_rev), .pos_now(pos_now), .busy(busy));
  ssip_mst #(.HALF_CYC(HC), .GAP_CYC(50), .STALE_CYC(500)) u_ssip_mst (.clk_sys(clk_sys), .rstn(rstn),
    .lnk(u_ssip_if.mst), .rd_req(rd_req), .rd_busy(rd_busy), .rd_word(rd_word), .rd_valid(rd_valid),
    .rd_stale(rd_stale));
  ssip_checker #(.POS_W(PW), .HALF_CYC(HC), .GAP_CYC(50)) u_ssip_checker (.clk_sys(clk_sys), .rstn(rstn),
    .sclk(u_ssip_if.sclk), .sdata(u_ssip_if.sdata));
  // Clock of 10 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Collects the bits on the wire at each falling clock edge after the start edge.
  always @(negedge u_ssip_if.sclk) begin
    if (nfall > 0) wire_w = {wire_w[PW-2:0], u_ssip_if.sdata};
    nfall = nfall + 1;
  end
  task check(input string name, input logic [PW-1:0] seen, input logic [PW-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task tick;
    @(posedge clk_sys);
    #1;
  endtask : tick
  task step(input int n, input logic cw);
    for (int i = 0; i < n; i++) begin
      shaft_cw = cw;
      shaft_step = 1'b1;
      tick;
      shaft_step = 1'b0;
      tick;
      exp_pos = (cw ^ dir_rev) ? exp_pos + 1'b1 : exp_pos - 1'b1;
    end
    check("pos_now", pos_now, exp_pos);
  endtask : step
  task req;
    rd_req = 1'b1;
    tick;
    rd_req = 1'b0;
  endtask : req
  // Waits for one word and judges it against the bench's own position count.
  task get(input logic [PW-1:0] exp, input logic stl);
    int k;
    k = 0;
    while (rd_valid !== 1'b1) begin
      tick;
      k++;
      if (k > 2000) begin
        failures++;
        final_report;
      end
    end
    check("rd_word", rd_word, exp);
    check("rd_stale", PW'(rd_stale), PW'(stl));
    check("wire_word", wire_w, exp);
    check("fall_count", PW'(nfall), PW'(PW + 1));
    check("busy_end", PW'(busy), PW'(1'b0));
    nfall = 0;
    tick;
  endtask : get
  task t_idle;
    check("idle_lines", PW'({u_ssip_if.sclk, u_ssip_if.sdata}), PW'(2'h3));
    req;
    get(exp_pos, 1'b1);
    check("rd_busy_end", PW'(rd_busy), PW'(1'b0));
    $display("test idle done");
  endtask : t_idle
  task t_dir;
    step(5, 1'b1);
    req;
    get(exp_pos, 1'b0);
    dir_rev = 1'b1;
    repeat (4) tick; // Let the direction filter settle.
    step(3, 1'b1);
    step(2, 1'b0);
    req;
    get(exp_pos, 1'b0);
    dir_rev = 1'b0;
    repeat (4) tick; // Let the direction filter settle.
    step(6, 1'b0);
    req;
    get(exp_pos, 1'b0);
    $display("test direction done");
  endtask : t_dir
  task t_hold;
    int k;
    req;
    k = 0;
    while (busy !== 1'b1 && k < 100) begin
      tick;
      k++;
    end
    check("busy", PW'(busy), PW'(1'b1));
    step(2, 1'b1);
    get(exp_pos - 2'h2, 1'b0);
    req;
    get(exp_pos, 1'b0);
    $display("test capture done");
  endtask : t_hold
  task t_b2b;
    req;
    tick;
    req;
    check("rd_busy", PW'(rd_busy), PW'(1'b1));
    get(exp_pos, 1'b0);
    get(exp_pos, 1'b0);
    $display("test back to back done");
  endtask : t_b2b
  task t_stale;
    repeat (600) tick;
    req;
    get(exp_pos, 1'b1);
    $display("test stale done");
  endtask : t_stale
  // Main sequence: reset for 8 cycles, then the scenarios in turn.
  initial begin
    rstn = 1'b0;
    shaft_step = 1'b0;
    shaft_cw = 1'b0;
    dir_rev = 1'b0;
    rd_req = 1'b0;
    exp_pos = '0;
    wire_w = '0;
    nfall = 0;
    failures = 0;
    comparisons = 0;
    repeat (8) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    tick;
    t_idle;
    t_dir;
    t_hold;
    t_b2b;
    t_stale;
    final_report;
  end
endmodule : testbench
`default_nettype wire
